// file: core/fab_unit.sv
// address calculation units and branch state machine
`timescale 1ns/100ps
`include "fab_map.svh"
module fab_unit
    import fab_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // address unit operations and RAM slots
    input  wire logic [7:0]  acuOp,
    input  wire logic [7:0]  acuRamSel,
    // address unit outputs
    output logic      [13:0] acuAddr,
    output logic      [1:0]  acuRamWe,
    output logic      [1:0]  acuEqual,
    // control word from the two stores
    input  wire logic        storeSel,
    input  wire logic        endOfBlockA,
    input  wire logic        endOfBlockB,
    // branch memory programming
    input  wire logic        smWe,
    input  wire logic [2:0]  smWrIdx,
    input  wire logic [2:0]  smNext,
    input  wire logic [7:0]  smEnable,
    input  wire logic [5:0]  smTarget,
    // datapath and global flags
    input  wire logic [5:0]  condFlags,
    // sequencer outputs
    output logic      [5:0]  progCounter,
    output logic      [2:0]  branchState,
    output logic             jumpTaken
);
    fab_addr_t addr_r [2];
    fab_addr_t step_r [2];
    fab_addr_t lower_r [2];
    fab_addr_t upper_r [2];
    logic      wrap_r [2];
    fab_addr_t ram_r [2][`FAB_RAM_DEPTH];
    fab_addr_t out_nxt [2];
    logic      we_nxt [2];
    logic      eq_nxt [2];

    // codes that move the address register; the rest keep it
    function automatic logic loadsAddr(input fab_op_e op);
        logic r;
        r = 1'b0;
        unique case (op)
            OP_STEP_UP, OP_STEP_DOWN, OP_READ: begin
                r = 1'b1;
            end
            OP_CLEAR, OP_ADD_STEP, OP_SUB_STEP: begin
                r = 1'b1;
            end
            OP_HOLD, OP_WRITE, OP_FETCH_STEP, OP_FETCH_LOWER, OP_FETCH_UPPER: begin
                r = 1'b0;
            end
            OP_STORE_LOWER, OP_WRAP_ON, OP_WRAP_OFF, OP_STORE_UPPER, OP_STORE_STEP: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // codes that write the address RAM from the output value
    function automatic logic writesRam(input fab_op_e op);
        logic r;
        r = 1'b0;
        unique case (op)
            OP_WRITE, OP_STORE_LOWER, OP_STORE_UPPER, OP_STORE_STEP: begin
                r = 1'b1;
            end
            OP_HOLD, OP_STEP_UP, OP_STEP_DOWN, OP_READ, OP_FETCH_STEP: begin
                r = 1'b0;
            end
            OP_FETCH_LOWER, OP_FETCH_UPPER, OP_WRAP_ON, OP_WRAP_OFF: begin
                r = 1'b0;
            end
            OP_CLEAR, OP_ADD_STEP, OP_SUB_STEP: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gUnit
            fab_op_e   op;
            logic [3:0] sel;
            fab_addr_t ramRd;
            logic [7:0] sum;
            logic [7:0] diff;
            fab_addr_t incRes;
            fab_addr_t decRes;
            fab_addr_t addRes;
            fab_addr_t subRes;
            assign op    = fab_op_e'(acuOp[4*g +: 4]);
            assign sel   = acuRamSel[4*g +: 4];
            assign ramRd = ram_r[g][sel];
            assign sum   = {1'b0, addr_r[g]} + {1'b0, step_r[g]};
            assign diff  = {1'b0, addr_r[g]} - {1'b0, step_r[g]};

            // increment with modulo or full-range wrap
            always_comb begin
                if (wrap_r[g] && addr_r[g] == upper_r[g]) begin
                    incRes = lower_r[g];
                end else if (!wrap_r[g] && addr_r[g] == `FAB_ADDR_MAX) begin
                    incRes = `FAB_ADDR_RST;
                end else begin
                    incRes = addr_r[g] + 7'h01;
                end
            end

            always_comb begin
                if (wrap_r[g] && addr_r[g] == lower_r[g]) begin
                    decRes = upper_r[g];
                end else if (!wrap_r[g] && addr_r[g] == `FAB_ADDR_RST) begin
                    decRes = `FAB_ADDR_MAX;
                end else begin
                    decRes = addr_r[g] - 7'h01;
                end
            end

            // non-modulo overflow lands on sum-128, the same as (sum-127)-1
            always_comb begin
                if (wrap_r[g] && sum > {1'b0, upper_r[g]}) begin
                    addRes = 7'(sum - {1'b0, upper_r[g]} - 8'h01
                                + {1'b0, lower_r[g]});
                end else if (!wrap_r[g] && sum > {1'b0, `FAB_ADDR_MAX}) begin
                    addRes = 7'(sum - 8'h80);
                end else begin
                    addRes = sum[6:0];
                end
            end

            // borrow below lower bound folds back from the top bound;
            // without modulo the 7-bit wrap already gives 127-((step-addr)-1)
            always_comb begin
                if (wrap_r[g] && (diff[7] || diff[6:0] < lower_r[g])) begin
                    subRes = 7'(upper_r[g] - (step_r[g] - (addr_r[g] - lower_r[g]))
                                + 7'h01);
                end else begin
                    subRes = diff[6:0];
                end
            end

            always_comb begin
                out_nxt[g] = addr_r[g];
                we_nxt[g]  = 1'b0;
                unique case (op)
                    OP_HOLD: begin
                        out_nxt[g] = addr_r[g];
                    end
                    OP_STEP_UP: begin
                        out_nxt[g] = incRes;
                    end
                    OP_STEP_DOWN: begin
                        out_nxt[g] = decRes;
                    end
                    OP_READ: begin
                        out_nxt[g] = ramRd;
                    end
                    OP_WRITE: begin
                        we_nxt[g] = 1'b1;
                    end
                    OP_FETCH_STEP, OP_FETCH_LOWER, OP_FETCH_UPPER: begin
                        out_nxt[g] = addr_r[g];
                    end
                    OP_STORE_LOWER: begin
                        out_nxt[g] = lower_r[g];
                        we_nxt[g]  = 1'b1;
                    end
                    OP_STORE_UPPER: begin
                        out_nxt[g] = upper_r[g];
                        we_nxt[g]  = 1'b1;
                    end
                    OP_STORE_STEP: begin
                        out_nxt[g] = step_r[g];
                        we_nxt[g]  = 1'b1;
                    end
                    OP_WRAP_ON, OP_WRAP_OFF: begin
                        out_nxt[g] = addr_r[g];
                    end
                    OP_CLEAR: begin
                        out_nxt[g] = wrap_r[g] ? lower_r[g] : `FAB_ADDR_RST;
                    end
                    OP_ADD_STEP: begin
                        out_nxt[g] = addRes;
                    end
                    OP_SUB_STEP: begin
                        out_nxt[g] = subRes;
                    end
                endcase
            end

            // equal flag: upper match, top address (127) or zero
            assign eq_nxt[g] = (out_nxt[g] == upper_r[g])
                            || (out_nxt[g] == `FAB_ADDR_MAX)
                            || (out_nxt[g] == `FAB_ADDR_RST);

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    addr_r[g] <= `FAB_ADDR_RST;
                end else if (loadsAddr(op)) begin
                    addr_r[g] <= out_nxt[g];
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    step_r[g]  <= `FAB_ADDR_RST;
                    lower_r[g] <= `FAB_ADDR_RST;
                    upper_r[g] <= `FAB_ADDR_MAX;
                end else begin
                    if (op == OP_FETCH_STEP) begin
                        step_r[g] <= ramRd;
                    end
                    if (op == OP_FETCH_LOWER) begin
                        lower_r[g] <= ramRd;
                    end
                    if (op == OP_FETCH_UPPER) begin
                        upper_r[g] <= ramRd;
                    end
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    wrap_r[g] <= 1'b0;
                end else if (op == OP_WRAP_ON) begin
                    wrap_r[g] <= 1'b1;
                end else if (op == OP_WRAP_OFF) begin
                    wrap_r[g] <= 1'b0;
                end
            end

            // the RAM has no reset; software loads it before use
            always_ff @(posedge clk) begin
                if (writesRam(op)) begin
                    ram_r[g][sel] <= out_nxt[g];
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    acuAddr[7*g +: 7] <= `FAB_ADDR_RST;
                end else begin
                    acuAddr[7*g +: 7] <= out_nxt[g];
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    acuRamWe[g] <= 1'b0;
                end else begin
                    acuRamWe[g] <= we_nxt[g];
                end
            end

            // registered flag feeds the branch conditions one cycle late
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    acuEqual[g] <= 1'b0;
                end else begin
                    acuEqual[g] <= eq_nxt[g];
                end
            end
        end
    endgenerate

    // branch state machine memory: next state, condition enables, target
    logic [2:0] smNext_r [`FAB_SM_DEPTH];
    logic [7:0] smEn_r [`FAB_SM_DEPTH];
    fab_pc_t    smTgt_r [`FAB_SM_DEPTH];
    logic [2:0] state_r;
    fab_pc_t    pc_r;
    logic [7:0] conds;
    logic       endOfBlock;
    logic       jump;

    fab_pc_t    pc_nxt;
    logic [2:0] state_nxt;

    // one writable entry per branch state
    genvar e;
    generate
        for (e = 0; e < `FAB_SM_DEPTH; e++) begin : gEntry
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    smNext_r[e] <= `FAB_STATE_RST;
                    smEn_r[e]   <= 8'h00;
                    smTgt_r[e]  <= `FAB_PC_RST;
                end else if (smWe && smWrIdx == 3'(e)) begin
                    smNext_r[e] <= smNext;
                    smEn_r[e]   <= smEnable;
                    smTgt_r[e]  <= smTarget;
                end
            end
        end
    endgenerate

    assign conds      = {condFlags, acuEqual};
    assign endOfBlock = storeSel ? endOfBlockB : endOfBlockA;
    assign jump       = endOfBlock && |(conds & smEn_r[state_r]);

    // the counter wraps at the top of the store when no jump is set up
    always_comb begin
        pc_nxt    = pc_r + 6'h01;
        state_nxt = state_r;
        if (jump) begin
            pc_nxt    = smTgt_r[state_r];
            state_nxt = smNext_r[state_r];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_r    <= `FAB_PC_RST;
            state_r <= `FAB_STATE_RST;
        end else begin
            pc_r    <= pc_nxt;
            state_r <= state_nxt;
        end
    end

    assign progCounter = pc_r;
    assign branchState = state_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            jumpTaken <= 1'b0;
        end else begin
            jumpTaken <= jump;
        end
    end
endmodule

// file: core/fab_map.svh
// constants for the filter address and branch unit
// Summary of operation
// - two address units, sixteen 4-bit operations each
// - code 0 outputs address, holds it
// - code 1 increments with modulo or 127 wrap
// - code 2 decrements with modulo or 127 wrap
// - code 3 loads address from address RAM
// - code 4 writes address into address RAM
// - codes 5-7 load step, lower, upper from RAM
// - codes 8,14,15 output bound or step, write RAM
// - codes 9/10 set/clear modulo flag
// - code 11 clears to lower bound or zero
// - code 12 adds step with wrap
// - sequencer fetches from two control stores
// - program counter steps sequentially from zero
// - flags evaluated against conditions every cycle
// - jumps taken only at end-of-block instructions
// - branch memory holds state, enables, target
// - equal flag on upper match, end or zero
`ifndef FAB_MAP_SVH
`define FAB_MAP_SVH
`define FAB_ADDR_MAX    7'h7f
`define FAB_ADDR_RST    7'h00
`define FAB_PC_RST      6'h00
`define FAB_STATE_RST   3'h0
`define FAB_COND_NUM    8
`define FAB_SM_DEPTH    8
`define FAB_RAM_DEPTH   16
`endif

// file: core/fab_pkg.sv
// types for the filter address and branch unit
package fab_pkg;
    typedef enum logic [3:0] {
        OP_HOLD, OP_STEP_UP, OP_STEP_DOWN, OP_READ, OP_WRITE,
        OP_FETCH_STEP, OP_FETCH_LOWER, OP_FETCH_UPPER, OP_STORE_LOWER,
        OP_WRAP_ON, OP_WRAP_OFF, OP_CLEAR, OP_ADD_STEP, OP_SUB_STEP,
        OP_STORE_UPPER, OP_STORE_STEP
    } fab_op_e;
    typedef logic [6:0] fab_addr_t;
    typedef logic [5:0] fab_pc_t;
endpackage

// file: sim/fab_checker.sv
// checker for the filter address and branch unit
`timescale 1ns/100ps
module fab_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // address units
    input wire logic [7:0]  acuOp,
    input wire logic [13:0] acuAddr,
    input wire logic [1:0]  acuRamWe,
    input wire logic [1:0]  acuEqual,
    // sequencer
    input wire logic        storeSel,
    input wire logic        endOfBlockA,
    input wire logic        endOfBlockB,
    input wire logic [5:0]  progCounter,
    input wire logic        jumpTaken
);
    logic      wrap_r, run_r, bnd0_r, bnd1_r;
    wire logic end_of_block_bit;
    assign end_of_block_bit = storeSel ? endOfBlockB : endOfBlockA;
    // bound ops leave the output off the address register for one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {wrap_r, run_r, bnd0_r, bnd1_r} <= 4'h0;
        end else begin
            run_r <= 1'b1;
            bnd0_r <= acuOp[3:0] inside {4'h8, 4'he, 4'hf};
            bnd1_r <= acuOp[7:4] inside {4'h8, 4'he, 4'hf};
            if (acuOp[3:0] == 4'h9) wrap_r <= 1'b1;
            if (acuOp[3:0] == 4'ha) wrap_r <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_HOLD0: assert property (
        acuOp[3:0] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha} && !bnd0_r
        |=> acuAddr[6:0] == $past(acuAddr[6:0])) else $error("unit0 address moved");
    AST_HOLD1: assert property (
        acuOp[7:4] == 4'h0 && !bnd1_r
        |=> acuAddr[13:7] == $past(acuAddr[13:7])) else $error("unit1 address moved");
    AST_STEP_UP: assert property (
        acuOp[3:0] == 4'h1 && !wrap_r && !bnd0_r
        |=> acuAddr[6:0] == $past(acuAddr[6:0]) + 7'h01) else $error("bad step up");
    AST_STEP_DOWN: assert property (
        acuOp[3:0] == 4'h2 && !wrap_r && !bnd0_r
        |=> acuAddr[6:0] == $past(acuAddr[6:0]) - 7'h01) else $error("bad step down");
    AST_CLEAR: assert property (
        acuOp[3:0] == 4'hb && !wrap_r |=> acuAddr[6:0] == 7'h00) else $error("bad clear");
    AST_RAM_WE: assert property (
        1'b1 |=> acuRamWe == {$past(acuOp[7:4] inside {4'h4, 4'h8, 4'he, 4'hf}),
        $past(acuOp[3:0] inside {4'h4, 4'h8, 4'he, 4'hf})}) else $error("bad RAM write");
    AST_EQUAL: assert property (
        run_r && acuAddr[6:0] inside {7'h00, 7'h7f} |-> acuEqual[0]) else $error("no equal");
    AST_NO_JUMP: assert property (
        !end_of_block_bit |=> progCounter == $past(progCounter) + 6'h01 && !jumpTaken)
        else $error("counter left its sequence");
    AST_JUMP_EOB: assert property (
        jumpTaken |-> run_r && $past(end_of_block_bit)) else $error("jump outside block end");
    cover property (jumpTaken);
    cover property (acuRamWe[0]);
    cover property (run_r && acuEqual[0]);
endmodule
bind fab_unit fab_checker i_fab_checker (
    .clk(clk), .nrst(nrst), .acuOp(acuOp), .acuAddr(acuAddr), .acuRamWe(acuRamWe),
    .acuEqual(acuEqual), .storeSel(storeSel), .endOfBlockA(endOfBlockA),
    .endOfBlockB(endOfBlockB), .progCounter(progCounter), .jumpTaken(jumpTaken));

// file: sim/fab_far_model.sv
// far side model: control store words and datapath flags
`timescale 1ns/100ps
module fab_far_model (
    // sequencer view and settings
    input  wire logic [5:0] progCounter,
    input  wire logic [5:0] blockLen,
    input  wire logic [5:0] flagsIn,
    // control word and flags
    output logic            storeSel,
    output logic            endOfBlockA,
    output logic            endOfBlockB,
    output logic      [5:0] condFlags
);
    logic hit;
    assign hit = progCounter == blockLen;
    assign storeSel = progCounter[0];
    // unselected store shows the opposite, so a wrong pick shows up
    assign endOfBlockA = storeSel ? ~hit : hit;
    assign endOfBlockB = storeSel ? hit : ~hit;
    assign condFlags = flagsIn;
endmodule

// file: sim/tb.sv
// self-checking bench for the filter address and branch unit
`timescale 1ns/100ps
module tb;
    logic        clk = 0, nrst = 0, smWe = 0;
    logic [7:0]  acuOp = 0, acuRamSel = 0, smEnable = 0;
    logic [2:0]  smWrIdx = 0, smNext = 0, branchState;
    logic [5:0]  smTarget = 0, blockLen = 6'h03, flagsIn = 0, condFlags, progCounter;
    logic [13:0] acuAddr;
    logic [1:0]  acuRamWe, acuEqual;
    logic        storeSel, endOfBlockA, endOfBlockB, jumpTaken;
    logic [6:0]  ea = 0, st = 0, ram [16];
    integer      seed = 32'h0358, errTotal = 0, checks = 0, i;
    always #5 clk = ~clk;
    fab_unit i_fab_unit (.clk(clk), .nrst(nrst), .acuOp(acuOp), .acuRamSel(acuRamSel),
        .acuAddr(acuAddr), .acuRamWe(acuRamWe), .acuEqual(acuEqual), .storeSel(storeSel),
        .endOfBlockA(endOfBlockA), .endOfBlockB(endOfBlockB), .smWe(smWe),
        .smWrIdx(smWrIdx), .smNext(smNext), .smEnable(smEnable), .smTarget(smTarget),
        .condFlags(condFlags), .progCounter(progCounter), .branchState(branchState),
        .jumpTaken(jumpTaken));
    fab_far_model i_fab_far_model (.progCounter(progCounter), .blockLen(blockLen),
        .flagsIn(flagsIn), .storeSel(storeSel), .endOfBlockA(endOfBlockA),
        .endOfBlockB(endOfBlockB), .condFlags(condFlags));
    task summarize;
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cmp(input string n, input logic [13:0] e, input logic [13:0] g);
        checks++;
        if (g !== e) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // plain 7-bit wrap matches every non-modulo arithmetic case
    function logic [6:0] nx(input logic [3:0] c, input logic [6:0] a, input logic [6:0] s);
        case (c)
            4'h1: return a + 7'h01;
            4'h2: return a - 7'h01;
            4'hb: return 7'h00;
            4'hc: return a + s;
            4'hd: return a - s;
            default: return a;
        endcase
    endfunction
    // op for one cycle on both units, then hold; result settled on return
    task doOp(input logic [3:0] c, input logic [3:0] s);
        @(posedge clk);
        acuOp <= {c, c};
        acuRamSel <= {s, s};
        @(posedge clk);
        acuOp <= 8'h00;
        #1;
    endtask
    task go(input logic [3:0] c, input logic [3:0] s);
        logic [6:0] o;
        logic [13:0] w;
        doOp(c, s);
        if (c == 4'h4) ram[s] = ea;
        if (c == 4'h3) ea = ram[s];
        if (c == 4'h5) st = ram[s];
        ea = nx(c, ea, st);
        o = (c == 4'hf) ? st : ea;
        cmp("acuAddr", {o, o}, acuAddr);
        w = (c inside {4'h4, 4'h8, 4'he, 4'hf}) ? 14'h0003 : 14'h0000;
        cmp("acuRamWe", w, {12'h000, acuRamWe});
        if (o == 7'h00 || o == 7'h7f) cmp("acuEqual", 14'h0003, {12'h000, acuEqual});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 16; i++) go(4'h4, i[3:0]);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            smWe <= 1'b1;
            smWrIdx <= i[2:0];
            smNext <= i[2:0] + 3'h1;
            smEnable <= 8'h04;
            smTarget <= 6'h05;
        end
        @(posedge clk);
        smWe <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            acuOp <= $random(seed);
            acuRamSel <= $random(seed);
        end
        doOp(4'ha, 4'h0);
        go(4'hb, 4'h0);
        go(4'h2, 4'h0);
        go(4'h1, 4'h0);
        go(4'h2, 4'h0);
        go(4'h4, 4'h3);
        go(4'hb, 4'h0);
        go(4'h3, 4'h3);
        go(4'h5, 4'h3);
        go(4'hb, 4'h0);
        go(4'hc, 4'h0);
        go(4'hc, 4'h0);
        go(4'hd, 4'h0);
        go(4'hb, 4'h0);
        go(4'hf, 4'h0);
        go(4'h0, 4'h0);
        @(posedge clk);
        flagsIn <= 6'h01;
        for (i = 0; i < 200 && jumpTaken !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        cmp("jumpTaken", 14'h0001, {13'h0000, jumpTaken});
        cmp("progCounter", 14'h0005, {8'h00, progCounter});
        cmp("branchState", 14'h0001, {11'h000, branchState});
        summarize();
    end
endmodule
